/* common/mtc_map.svh */
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH

// byte select codes from the bus receiver
`define MTC_SEL_CONTROL_ZERO 2'h0
`define MTC_SEL_FREQUENCY_LOW 2'h1
`define MTC_SEL_CONTROL_ONE 2'h2

// field positions in control_byte_zero
`define MTC_PUMP_TEST_LSB 0
`define MTC_PUMP_TEST_MSB 2
`define MTC_SUBCARRIER_LSB 3
`define MTC_SUBCARRIER_MSB 4
// field positions in frequency_low_byte
`define MTC_SECONDARY_LSB 0
`define MTC_SECONDARY_MSB 1
// field positions in control_byte_one
`define MTC_AUDIO_LSB 4
`define MTC_AUDIO_MSB 6
`define MTC_RATIO_LSB 1
`define MTC_RATIO_MSB 3

// reset values of the stored bytes
`define MTC_CONTROL_ZERO_RESET 8'h00
`define MTC_FREQUENCY_LOW_RESET 8'h00
`define MTC_CONTROL_ONE_RESET 8'h00

// fixed-index variant codes
`define MTC_FIXED_AUDIO_CODE 3'h7
`define MTC_FIXED_RATIO_LOW 3'h1
`define MTC_FIXED_RATIO_HIGH 3'h5

// transient inhibit timing
`define MTC_INHIBIT_TIME_NS 64'd263000000
`define MTC_LINK_CLK_PERIOD_PS 64'd12000
`define MTC_INHIBIT_CYCLES \
  ((`MTC_INHIBIT_TIME_NS * 64'd1000 + `MTC_LINK_CLK_PERIOD_PS - 64'd1) \
   / `MTC_LINK_CLK_PERIOD_PS)
`define MTC_SPEEDUP_STEP 32'h00000040

`endif

/* common/mtc_pkg.sv */
package mtc_pkg;

  // what drives one current source of the phase comparator
  typedef enum logic [1:0] {
    MTC_SRC_OFF = 2'b00,
    MTC_SRC_COMPARATOR = 2'b01,
    MTC_SRC_FORCED_ON = 2'b10,
    MTC_SRC_DIVIDER = 2'b11
  } mtc_src_e;

  // effective charge pump operating state
  typedef enum logic [3:0] {
    MTC_ST_NORMAL_PLAIN = 4'b0000,
    MTC_ST_NO_PATTERN = 4'b0001,
    MTC_ST_UPPER_ON = 4'b0010,
    MTC_ST_LOWER_ON = 4'b0011,
    MTC_ST_INVERTED = 4'b0100,
    MTC_ST_HIGH_Z = 4'b0101,
    MTC_ST_REF_DIV = 4'b0110,
    MTC_ST_PROG_DIV = 4'b0111,
    MTC_ST_INHIBIT_OFF = 4'b1000,
    MTC_ST_INHIBIT_FORCED = 4'b1001,
    MTC_ST_INHIBIT_FAST = 4'b1010
  } mtc_state_e;

endpackage

/* hw/mtc_control_decode.sv */
`timescale 1ns/1ps
`include "mtc_map.svh"

// How it works
// - pump_test_select sits in control_byte_zero bits 2..0, bit 2 is msb.
// - pump_test_select zero hands pump and inhibit to secondary selector.
// - state 1 runs normally but keeps the test pattern generator off.
// - state 2 upper on lower off; state 5 both off, output floats.
// - state 3 lower source forced on, upper source off.
// - state 4 inverted normal; host uses it with inverting amplifier.
// - state 6 puts reference divider on upper source, lower off.
// - state 7 puts half-rate programmable divider on lower, upper off.
// - secondary_test_select in frequency_low_byte bits 1..0, if primary zero.
// - secondary 00 is normal operation with non-inverted polarity.
// - secondary 01 is inverted normal with transient inhibit disabled.
// - secondary 10 is inverted normal with RF output held off.
// - entering secondary 11 restarts inhibit counter at 64 times speed.
// - inverted polarity sources when frequency high, sinks when low.
// - states 6 and 7 also put sound divider on sound upper source.
// - subcarrier_freq_select from control_byte_zero bits 4..3.
// - audio_sensitivity_code in control_byte_one bits 6..4; fixed 111.
// - picture_sound_ratio_code in control_byte_one bits 3..1; fixed 001/101.
// - RF output stays off for 263 ms after power-on or standby exit.
// - reference divider divides crystal by 128 for the comparison rate.
module mtc_control_decode #(
  parameter logic FIXED_INDEX_VARIANT = 1'b0,
  parameter logic [31:0] INHIBIT_CYCLES = 32'(`MTC_INHIBIT_CYCLES)
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ref_clk_i,
  input wire logic byte_write_i,
  input wire logic [1:0] byte_select_i,
  input wire logic [7:0] byte_data_i,
  input wire logic standby_i,
  output mtc_pkg::mtc_src_e pump_upper_src_o,
  output mtc_pkg::mtc_src_e pump_lower_src_o,
  output logic pump_invert_o,
  output logic pattern_disable_o,
  output logic sound_pump_test_o,
  output logic rf_output_enable_o,
  output logic [1:0] subcarrier_freq_select_o,
  output logic [2:0] audio_sensitivity_code_o,
  output logic [2:0] picture_sound_ratio_code_o
);

  ////////////////////////////////////////////////////////////////////////////
  // stored control bytes

  logic [7:0] control_byte_zero_reg;
  logic [7:0] frequency_low_byte_reg;
  logic [7:0] control_byte_one_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      control_byte_zero_reg <= `MTC_CONTROL_ZERO_RESET;
    end else if (byte_write_i && byte_select_i == `MTC_SEL_CONTROL_ZERO) begin
      control_byte_zero_reg <= byte_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      frequency_low_byte_reg <= `MTC_FREQUENCY_LOW_RESET;
    end else if (byte_write_i && byte_select_i == `MTC_SEL_FREQUENCY_LOW) begin
      frequency_low_byte_reg <= byte_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      control_byte_one_reg <= `MTC_CONTROL_ONE_RESET;
    end else if (byte_write_i && byte_select_i == `MTC_SEL_CONTROL_ONE) begin
      control_byte_one_reg <= byte_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating state decode

  logic [2:0] pump_test_select;
  logic [1:0] secondary_test_select;
  mtc_pkg::mtc_state_e state_next;

  assign pump_test_select =
    control_byte_zero_reg[`MTC_PUMP_TEST_MSB:`MTC_PUMP_TEST_LSB];
  assign secondary_test_select =
    frequency_low_byte_reg[`MTC_SECONDARY_MSB:`MTC_SECONDARY_LSB];

  function automatic mtc_pkg::mtc_state_e mtc_decode_state(
    input logic [2:0] primary,
    input logic [1:0] secondary
  );
    mtc_pkg::mtc_state_e st;
    st = mtc_pkg::MTC_ST_NORMAL_PLAIN;
    // zero primary defers to secondary selector
    if (primary == 3'h0) begin
      unique case (secondary)
        2'b00: st = mtc_pkg::MTC_ST_NORMAL_PLAIN;
        2'b01: st = mtc_pkg::MTC_ST_INHIBIT_OFF;
        2'b10: st = mtc_pkg::MTC_ST_INHIBIT_FORCED;
        2'b11: st = mtc_pkg::MTC_ST_INHIBIT_FAST;
      endcase
    end else begin
      st = mtc_pkg::mtc_state_e'({1'b0, primary});
    end
    return st;
  endfunction

  assign state_next =
    mtc_decode_state(pump_test_select, secondary_test_select);

  mtc_pkg::mtc_state_e state_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg <= mtc_pkg::MTC_ST_NORMAL_PLAIN;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current source steering

  // decoded from state_next so the pins follow a write by one edge
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pump_upper_src_o <= mtc_pkg::MTC_SRC_COMPARATOR;
      pump_lower_src_o <= mtc_pkg::MTC_SRC_COMPARATOR;
      pump_invert_o <= 1'b0;
      pattern_disable_o <= 1'b0;
      sound_pump_test_o <= 1'b0;
    end else begin
      pump_upper_src_o <= mtc_pkg::MTC_SRC_COMPARATOR;
      pump_lower_src_o <= mtc_pkg::MTC_SRC_COMPARATOR;
      // invert flag sources current when oscillator runs high
      pump_invert_o <= 1'b1;
      pattern_disable_o <= 1'b0;
      sound_pump_test_o <= 1'b0;
      unique case (state_next)
        mtc_pkg::MTC_ST_NORMAL_PLAIN: pump_invert_o <= 1'b0;
        mtc_pkg::MTC_ST_NO_PATTERN: begin
          pattern_disable_o <= 1'b1;
          pump_invert_o <= 1'b0;
        end
        mtc_pkg::MTC_ST_UPPER_ON: begin
          pump_upper_src_o <= mtc_pkg::MTC_SRC_FORCED_ON;
          pump_lower_src_o <= mtc_pkg::MTC_SRC_OFF;
        end
        mtc_pkg::MTC_ST_LOWER_ON: begin
          pump_upper_src_o <= mtc_pkg::MTC_SRC_OFF;
          pump_lower_src_o <= mtc_pkg::MTC_SRC_FORCED_ON;
        end
        mtc_pkg::MTC_ST_HIGH_Z: begin
          pump_upper_src_o <= mtc_pkg::MTC_SRC_OFF;
          pump_lower_src_o <= mtc_pkg::MTC_SRC_OFF;
        end
        mtc_pkg::MTC_ST_REF_DIV: begin
          pump_upper_src_o <= mtc_pkg::MTC_SRC_DIVIDER;
          pump_lower_src_o <= mtc_pkg::MTC_SRC_OFF;
          sound_pump_test_o <= 1'b1;
        end
        mtc_pkg::MTC_ST_PROG_DIV: begin
          pump_upper_src_o <= mtc_pkg::MTC_SRC_OFF;
          pump_lower_src_o <= mtc_pkg::MTC_SRC_DIVIDER;
          sound_pump_test_o <= 1'b1;
        end
        mtc_pkg::MTC_ST_INVERTED,
        mtc_pkg::MTC_ST_INHIBIT_OFF,
        mtc_pkg::MTC_ST_INHIBIT_FORCED,
        mtc_pkg::MTC_ST_INHIBIT_FAST: begin
        end
        // unused encodings of the 4-bit state
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sound settings

  logic [2:0] audio_raw;
  logic [2:0] ratio_raw;

  assign audio_raw = control_byte_one_reg[`MTC_AUDIO_MSB:`MTC_AUDIO_LSB];
  assign ratio_raw = control_byte_one_reg[`MTC_RATIO_MSB:`MTC_RATIO_LSB];

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      subcarrier_freq_select_o <= 2'h0;
      audio_sensitivity_code_o <= 3'h0;
      picture_sound_ratio_code_o <= 3'h0;
    end else begin
      subcarrier_freq_select_o <=
        control_byte_zero_reg[`MTC_SUBCARRIER_MSB:`MTC_SUBCARRIER_LSB];
      // audio code, pinned in the fixed variant
      audio_sensitivity_code_o <= FIXED_INDEX_VARIANT ?
        `MTC_FIXED_AUDIO_CODE : audio_raw;
      // ratio code; fixed variant snaps to nearest supported code
      picture_sound_ratio_code_o <= !FIXED_INDEX_VARIANT ? ratio_raw :
        (ratio_raw[2] ? `MTC_FIXED_RATIO_HIGH : `MTC_FIXED_RATIO_LOW);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // restart requests toward the inhibit counter

  logic standby_meta_reg;
  logic standby_sync_reg;
  logic standby_prev_reg;
  logic restart_toggle_reg;
  logic fast_reg;
  logic fast_entry;
  logic standby_exit;
  logic restart_now;

  // standby is a pin: two flops before anything reads it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      standby_meta_reg <= 1'b0;
      standby_sync_reg <= 1'b0;
      standby_prev_reg <= 1'b0;
    end else begin
      standby_meta_reg <= standby_i;
      standby_sync_reg <= standby_meta_reg;
      standby_prev_reg <= standby_sync_reg;
    end
  end

  assign standby_exit = standby_prev_reg && !standby_sync_reg;
  assign fast_entry = state_next == mtc_pkg::MTC_ST_INHIBIT_FAST
    && state_reg != mtc_pkg::MTC_ST_INHIBIT_FAST;
  // one restart event feeds the toggle, the pending flag and the gate
  assign restart_now = standby_exit || fast_entry;

  // standby exit restarts count
  // a toggle, not a pulse, so either clock ratio sees it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      restart_toggle_reg <= 1'b0;
    end else if (restart_now) begin
      restart_toggle_reg <= !restart_toggle_reg;
    end
  end

  // step size crosses as a level; a slow step or two is harmless
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fast_reg <= 1'b0;
    end else begin
      fast_reg <= state_reg == mtc_pkg::MTC_ST_INHIBIT_FAST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inhibit counter on the reference clock

  logic link_reset_meta_reg;
  logic link_reset_reg;
  logic [2:0] link_toggle_reg;
  logic [1:0] link_fast_reg;
  logic [31:0] inhibit_count_reg;
  logic inhibit_done_reg;
  logic [31:0] inhibit_step;
  logic link_restart;

  // power-on reset carried over so the count starts fresh
  always_ff @(posedge ref_clk_i) begin
    link_reset_meta_reg <= reset_i;
    link_reset_reg <= link_reset_meta_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (link_reset_reg) begin
      link_toggle_reg <= 3'h0;
      link_fast_reg <= 2'h0;
    end else begin
      link_toggle_reg <= {link_toggle_reg[1:0], restart_toggle_reg};
      link_fast_reg <= {link_fast_reg[0], fast_reg};
    end
  end

  assign link_restart = link_toggle_reg[2] ^ link_toggle_reg[1];
  assign inhibit_step = link_fast_reg[1] ? `MTC_SPEEDUP_STEP : 32'h00000001;

  // 32 bits hold the full default span plus one sped-up step
  // hold output off until timeout
  always_ff @(posedge ref_clk_i) begin
    if (link_reset_reg || link_restart) begin
      inhibit_count_reg <= 32'h00000000;
      inhibit_done_reg <= 1'b0;
    end else if (!inhibit_done_reg) begin
      inhibit_count_reg <= inhibit_count_reg + inhibit_step;
      if (inhibit_count_reg + inhibit_step >= INHIBIT_CYCLES) begin
        inhibit_done_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RF output enable back on the main clock

  logic done_meta_reg;
  logic done_sync_reg;
  logic restart_pending_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
    end else begin
      done_meta_reg <= inhibit_done_reg;
      done_sync_reg <= done_meta_reg;
    end
  end

  // a stale done must not leak through before the restart lands
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      restart_pending_reg <= 1'b0;
    end else if (restart_now) begin
      restart_pending_reg <= 1'b1;
    end else if (!done_sync_reg) begin
      restart_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rf_output_enable_o <= 1'b0;
    end else if (standby_sync_reg) begin
      rf_output_enable_o <= 1'b0;
    end else begin
      unique case (state_reg)
        mtc_pkg::MTC_ST_INHIBIT_OFF: rf_output_enable_o <= 1'b1;
        mtc_pkg::MTC_ST_INHIBIT_FORCED: rf_output_enable_o <= 1'b0;
        default: rf_output_enable_o <= done_sync_reg
          && !restart_pending_reg && !restart_now;
      endcase
    end
  end

endmodule // mtc_control_decode

/* sim/mtc_control_decode_asserts.sv */
`timescale 1ns/1ps
module mtc_control_decode_asserts #(
  parameter logic FIXED_INDEX_VARIANT = 1'b0,
  parameter logic [31:0] INHIBIT_CYCLES = 32'd200
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic byte_write_i,
  input wire logic [1:0] byte_select_i,
  input wire logic [7:0] byte_data_i,
  input wire logic standby_i,
  input wire mtc_pkg::mtc_src_e pump_upper_src_o,
  input wire mtc_pkg::mtc_src_e pump_lower_src_o,
  input wire logic pump_invert_o,
  input wire logic pattern_disable_o,
  input wire logic sound_pump_test_o,
  input wire logic rf_output_enable_o,
  input wire logic [1:0] subcarrier_freq_select_o,
  input wire logic [2:0] audio_sensitivity_code_o,
  input wire logic [2:0] picture_sound_ratio_code_o
);
  logic [7:0] c0_q;
  logic [1:0] fl_q;
  logic [7:0] c1_q;
  logic [1:0] quiet_q;
  logic [2:0] awake_q;
  logic q;
  logic [2:0] p;
  // shadow bytes; select 3 is dropped like the design does
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      c0_q <= 8'h00;
      fl_q <= 2'h0;
      c1_q <= 8'h00;
    end else if (byte_write_i) begin
      if (byte_select_i == 2'h0) c0_q <= byte_data_i;
      if (byte_select_i == 2'h1) fl_q <= byte_data_i[1:0];
      if (byte_select_i == 2'h2) c1_q <= byte_data_i;
    end
  end
  // settle window, outputs lag a write by up to two edges
  always_ff @(posedge clock_i) begin
    if (reset_i || byte_write_i) quiet_q <= 2'h0;
    else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
  end
  // standby-free time, for checks that need the pin settled
  always_ff @(posedge clock_i) begin
    if (reset_i || standby_i) awake_q <= 3'h0;
    else if (awake_q != 3'h7) awake_q <= awake_q + 3'h1;
  end
  assign q = (quiet_q == 2'h3);
  assign p = c0_q[2:0];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_UPPER_ON: assert property (q && p == 3'h2 |->
    pump_upper_src_o == mtc_pkg::MTC_SRC_FORCED_ON
    && pump_lower_src_o == mtc_pkg::MTC_SRC_OFF) else $error("state 2 bad");
  AST_HIGH_Z: assert property (q && p == 3'h5 |->
    pump_upper_src_o == mtc_pkg::MTC_SRC_OFF
    && pump_lower_src_o == mtc_pkg::MTC_SRC_OFF) else $error("state 5 bad");
  AST_LOWER_ON: assert property (q && p == 3'h3 |->
    pump_lower_src_o == mtc_pkg::MTC_SRC_FORCED_ON
    && pump_upper_src_o == mtc_pkg::MTC_SRC_OFF) else $error("state 3 bad");
  AST_REF_DIV: assert property (q && p == 3'h6 |->
    pump_upper_src_o == mtc_pkg::MTC_SRC_DIVIDER
    && pump_lower_src_o == mtc_pkg::MTC_SRC_OFF) else $error("state 6 bad");
  AST_PROG_DIV: assert property (q && p == 3'h7 |->
    pump_lower_src_o == mtc_pkg::MTC_SRC_DIVIDER
    && pump_upper_src_o == mtc_pkg::MTC_SRC_OFF) else $error("state 7 bad");
  AST_NO_PATTERN: assert property (q |->
    pattern_disable_o == (p == 3'h1)) else $error("pattern lock bad");
  AST_POLARITY: assert property (
    q && (p == 3'h4 || p == 3'h0) |->
    pump_invert_o == (p == 3'h4 || fl_q != 2'h0)) else $error("polarity bad");
  AST_SOUND_TEST: assert property (q |->
    sound_pump_test_o == (p[2:1] == 2'h3)) else $error("sound test bad");
  AST_SUBCARRIER: assert property (q |->
    subcarrier_freq_select_o == c0_q[4:3]) else $error("subcarrier bad");
  AST_CODES: assert property (q |->
    audio_sensitivity_code_o == (FIXED_INDEX_VARIANT ? 3'h7 : c1_q[6:4])
    && picture_sound_ratio_code_o == (FIXED_INDEX_VARIANT ?
    (c1_q[3] ? 3'h5 : 3'h1) : c1_q[3:1])) else $error("codes bad");
  AST_FORCED_OFF: assert property (q && p == 3'h0 && fl_q == 2'h2 |->
    !rf_output_enable_o) else $error("forced inhibit bad");
  AST_INHIBIT_OFF: assert property (q && p == 3'h0 && fl_q == 2'h1
    && awake_q == 3'h7 |-> rf_output_enable_o) else $error("inhibit off bad");
  AST_EXIT_QUIET: assert property (q && awake_q != 3'h0
    && awake_q != 3'h7 && !(p == 3'h0 && fl_q == 2'h1)
    |-> !rf_output_enable_o) else $error("rf on after standby");
  AST_STANDBY: assert property (standby_i [*8] |=>
    !rf_output_enable_o) else $error("standby rf bad");
endmodule // mtc_control_decode_asserts

/* sim/mtc_host_model.sv */
`timescale 1ns/1ps
module mtc_host_model (
  input wire logic clock_i,
  output logic byte_write_o,
  output logic [1:0] byte_select_o,
  output logic [7:0] byte_data_o
);
  initial begin
    byte_write_o = 1'b0;
    byte_select_o = 2'h3;
    byte_data_o = 8'h00;
  end
  // one-cycle strobe; released data is inverted so stale reuse shows
  task automatic write_byte(input logic [1:0] sel, input logic [7:0] data);
    @(posedge clock_i);
    byte_write_o <= 1'b1;
    byte_select_o <= sel;
    byte_data_o <= data;
    @(posedge clock_i);
    byte_write_o <= 1'b0;
    byte_data_o <= ~data;
  endtask
endmodule // mtc_host_model

/* sim/mtc_control_decode_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t act=%0h exp=%0h", $time, (a), (e)); end end
bind mtc_control_decode mtc_control_decode_asserts #(
  .FIXED_INDEX_VARIANT(FIXED_INDEX_VARIANT),
  .INHIBIT_CYCLES(INHIBIT_CYCLES)
) u_ast (
  .clock_i(clock_i),
  .reset_i(reset_i),
  .byte_write_i(byte_write_i),
  .byte_select_i(byte_select_i),
  .byte_data_i(byte_data_i),
  .standby_i(standby_i),
  .pump_upper_src_o(pump_upper_src_o),
  .pump_lower_src_o(pump_lower_src_o),
  .pump_invert_o(pump_invert_o),
  .pattern_disable_o(pattern_disable_o),
  .sound_pump_test_o(sound_pump_test_o),
  .rf_output_enable_o(rf_output_enable_o),
  .subcarrier_freq_select_o(subcarrier_freq_select_o),
  .audio_sensitivity_code_o(audio_sensitivity_code_o),
  .picture_sound_ratio_code_o(picture_sound_ratio_code_o)
);
module mtc_control_decode_tb_top;
  logic clock_i = 1'b0;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic standby_i = 1'b0;
  logic wr_w;
  logic [1:0] sel_w;
  logic [7:0] dat_w;
  mtc_pkg::mtc_src_e up_w;
  mtc_pkg::mtc_src_e lo_w;
  logic inv_w, pat_w, snd_w, rf_w;
  logic [1:0] sub_w;
  logic [2:0] aud_w, rat_w;
  logic [2:0] aud_f_w, rat_f_w;
  int fails = 0;
  int compares = 0;
  int n;
  // up, lo, polarity (2 = skip), pattern, sound, rf (2 = skip)
  localparam logic [9:0] TAB [11] = '{10'h141, 10'h14A, 10'h222, 10'h0A2,
    10'h152, 10'h022, 10'h326, 10'h0E6, 10'h151, 10'h150, 10'h152};
  logic [9:0] e;
  always #12.5 clock_i = ~clock_i;
  always #6 ref_clk_i = ~ref_clk_i;
  mtc_host_model host (.clock_i(clock_i), .byte_write_o(wr_w),
    .byte_select_o(sel_w), .byte_data_o(dat_w));
  // small inhibit count keeps the run short
  mtc_control_decode #(.FIXED_INDEX_VARIANT(1'b0), .INHIBIT_CYCLES(32'd200))
  DUT (.clock_i(clock_i), .reset_i(reset_i), .ref_clk_i(ref_clk_i),
    .byte_write_i(wr_w), .byte_select_i(sel_w), .byte_data_i(dat_w),
    .standby_i(standby_i), .pump_upper_src_o(up_w), .pump_lower_src_o(lo_w),
    .pump_invert_o(inv_w), .pattern_disable_o(pat_w),
    .sound_pump_test_o(snd_w), .rf_output_enable_o(rf_w),
    .subcarrier_freq_select_o(sub_w), .audio_sensitivity_code_o(aud_w),
    .picture_sound_ratio_code_o(rat_w));
  // fixed-index variant fed the same bytes
  mtc_control_decode #(.FIXED_INDEX_VARIANT(1'b1), .INHIBIT_CYCLES(32'd200))
  DUT_FIXED (.clock_i(clock_i), .reset_i(reset_i), .ref_clk_i(ref_clk_i),
    .byte_write_i(wr_w), .byte_select_i(sel_w), .byte_data_i(dat_w),
    .standby_i(standby_i), .pump_upper_src_o(), .pump_lower_src_o(),
    .pump_invert_o(), .pattern_disable_o(), .sound_pump_test_o(),
    .rf_output_enable_o(), .subcarrier_freq_select_o(),
    .audio_sensitivity_code_o(aud_f_w), .picture_sound_ratio_code_o(rat_f_w));
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    host.write_byte(sel, data);
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_rf();
    n = 0;
    while (rf_w !== 1'b1 && n < 300) begin
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask
  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (40) @(posedge clock_i);
    #1;
    `CHK(rf_w, 1'b0)
    wait_rf();
    `CHK(rf_w, 1'b1)
    `CHK(n > 30, 1'b1)
    for (int i = 0; i < 11; i++) begin
      e = TAB[i];
      wr(2'h1, (i < 8) ? 8'h00 : 8'(i - 7));
      wr(2'h0, (i < 8) ? 8'(i) : 8'h00);
      `CHK(up_w, e[9:8])
      `CHK(lo_w, e[7:6])
      if (e[5:4] != 2'h2) `CHK(inv_w, e[4])
      `CHK(pat_w, e[3])
      `CHK(snd_w, e[2])
      if (e[1:0] != 2'h2) `CHK(rf_w, e[0])
    end
    // re-enter the fast code from the forced one: rf must restart low
    wr(2'h1, 8'h02);
    host.write_byte(2'h1, 8'h03);
    repeat (2) @(posedge clock_i);
    #1;
    `CHK(rf_w, 1'b0)
    wait_rf();
    `CHK(n < 20, 1'b1)
    wr(2'h1, 8'h00);
    @(posedge clock_i);
    standby_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    #1;
    `CHK(rf_w, 1'b0)
    @(posedge clock_i);
    standby_i <= 1'b0;
    repeat (40) @(posedge clock_i);
    #1;
    `CHK(rf_w, 1'b0)
    wait_rf();
    repeat (50) @(posedge clock_i);
    #1;
    `CHK(rf_w, 1'b1)
    for (int s = 0; s < 4; s++) begin
      wr(2'h0, {3'h0, 2'(s), 3'h4});
      `CHK(sub_w, 2'(s))
    end
    wr(2'h2, 8'hDA);
    `CHK(aud_w, 3'h5)
    `CHK(rat_w, 3'h5)
    `CHK(aud_f_w, 3'h7)
    `CHK(rat_f_w, 3'h5)
    wr(2'h2, 8'h24);
    wr(2'h3, 8'hFF);
    `CHK(aud_w, 3'h2)
    `CHK(rat_w, 3'h2)
    `CHK(aud_f_w, 3'h7)
    `CHK(rat_f_w, 3'h1)
    finish_test();
  end
endmodule // mtc_control_decode_tb_top
